// ### hdl/config_lock_and_strap_status.sv
// apb register bank for configuration lock, rom protect and strap status
`timescale 1ns/1ps

// Overview of operation
// RULE1 - lock bit 7 set makes indices 20h to 3Fh read-only, writes ignored
// RULE2 - software cannot clear the lock; only power-on or system reset clears it
// RULE3 - window field codes 000..011 give 1..4 us, 100 disables the guarantee
// RULE4 - timer starts when refresh ends; others granted only after it expires
// RULE5 - window field resets to 100, no guaranteed cpu window
// RULE6 - a set protect bit suppresses rom chip select for its segment
// RULE7 - protect bits 3,2,1,0 map to F, E, C, D 64k segments
// RULE8 - protect bits are set-only; cleared only by power removal
// RULE9 - status bit 7 shows the latched cache module presence strap, low present
// RULE10 - status bit 6 shows cache policy strap: 0 write-back, 1 write-through
// RULE11 - status bit 3 shows strap 3: 1 power-management input, 0 direction control
// RULE12 - status bit 1 shows strap 1: 0 local request/grant, 1 extra row strobes
// RULE13 - status bit 0 shows strap 0: 0 local ready, 1 zero-wait-state input
// RULE14 - strap lines are sampled at the power-good rising edge and held
// RULE15 - locked writes complete without error; reserved status bits read zero
module config_lock_and_strap_status #(
    parameter int ADDR_W = 12,
    parameter int CYC_US = cfg_lock_pkg::CYC_PER_US
) (
    // clock and power-on reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // system reset and power good
    input  wire logic                 sys_reset,
    input  wire logic                 power_good_in,
    // strap lines
    input  wire cfg_lock_pkg::straps_t straps_in,
    // bus arbitration
    input  wire logic                 refresh_n,
    output logic                      cpu_window_active,
    output logic                      other_grant_allowed,
    // boot rom select
    input  wire logic [3:0]           rom_seg_addr,
    input  wire logic                 rom_select_raw_n,
    output logic                      boot_rom_select_n,
    // pin function selects and cache status
    output logic                      ext_power_mgmt_sel,
    output logic                      row_strobe_sel,
    output logic                      zero_wait_state_sel,
    output logic                      cache_module_present,
    output logic                      cache_write_through,
    // lock status
    output logic                      config_locked
);

    // ==========================================================
    // block state

    typedef struct packed {
        logic                  lock;
        logic [2:0]            window_sel;
        logic [3:0]            protect;
        cfg_lock_pkg::straps_t straps;
        logic                  power_good_prev;
        logic [7:0]            rdata;
        logic                  err;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ==========================================================
    // decode helpers

    // register index from a byte address; low two bits ignored
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[9:2];
    endfunction

    // index falls in the range the lock freezes
    function automatic logic in_lock_range(input logic [7:0] idx);
        in_lock_range = (idx >= cfg_lock_pkg::IDX_LOCK_LO)
                     && (idx <= cfg_lock_pkg::IDX_LOCK_HI);
    endfunction

    // only the two registers of this bank are mapped
    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == cfg_lock_pkg::IDX_CTRL)
                 || (idx == cfg_lock_pkg::IDX_STATUS);
    endfunction

    // protect bit covering a 64k segment of the boot area
    function automatic logic seg_protected(input logic [3:0] seg,
                                           input logic [3:0] prot);
        unique case (seg)
            4'hf:    seg_protected = prot[3]; // RULE7
            4'he:    seg_protected = prot[2]; // RULE7
            4'hc:    seg_protected = prot[1]; // RULE7
            4'hd:    seg_protected = prot[0]; // RULE7
            default: seg_protected = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // register images

    logic [7:0] ctrl_image;
    logic [7:0] status_image;

    // control register as read back
    always_comb begin
        ctrl_image = 8'h00;
        ctrl_image[cfg_lock_pkg::CTRL_LOCK_BIT] = s_q.lock;
        ctrl_image[cfg_lock_pkg::CTRL_WIN_LSB +: 3] = s_q.window_sel;
        ctrl_image[cfg_lock_pkg::CTRL_PROT_LSB +: 4] = s_q.protect;
    end

    // status register; bits 5:4 and 2 stay zero
    always_comb begin
        status_image = 8'h00; // RULE15
        status_image[cfg_lock_pkg::STS_CMOD_BIT] = s_q.straps.cache_module_present_n; // RULE9
        status_image[cfg_lock_pkg::STS_POLICY_BIT] = s_q.straps.cache_policy_strap; // RULE10
        status_image[cfg_lock_pkg::STS_FN3_BIT] = s_q.straps.pin_function_strap_3; // RULE11
        status_image[cfg_lock_pkg::STS_FN1_BIT] = s_q.straps.pin_function_strap_1; // RULE12
        status_image[cfg_lock_pkg::STS_FN0_BIT] = s_q.straps.pin_function_strap_0; // RULE13
    end

    // ==========================================================
    // bus phases

    logic       setup_phase;
    logic       write_commit;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic       lane0;

    // the slave answers in the first access cycle; read data is
    // captured in setup so that prdata always comes from a flop
    assign setup_phase  = psel && !penable;
    assign write_commit = psel && penable && pwrite;
    assign idx          = reg_index(paddr);
    assign wbyte        = pwdata[7:0];
    assign lane0        = pstrb[0];

    // ==========================================================
    // next state

    logic power_good_rise;

    always_comb begin
        s_d = s_q;
        s_d.power_good_prev = power_good_in;
        power_good_rise = power_good_in && !s_q.power_good_prev;

        // read data and error captured at setup
        if (setup_phase) begin
            s_d.err = !is_mapped(idx);
            if (pwrite) begin
                s_d.rdata = 8'h00;
            end else if (idx == cfg_lock_pkg::IDX_CTRL) begin
                s_d.rdata = ctrl_image;
            end else if (idx == cfg_lock_pkg::IDX_STATUS) begin
                s_d.rdata = status_image;
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        // control write; the lock freezes the whole range, itself included
        if (write_commit && lane0 && (idx == cfg_lock_pkg::IDX_CTRL)
            && !(s_q.lock && in_lock_range(idx))) begin // RULE1
            // lock can be set by software but never cleared by it
            s_d.lock = s_q.lock | wbyte[cfg_lock_pkg::CTRL_LOCK_BIT]; // RULE2
            s_d.window_sel = wbyte[cfg_lock_pkg::CTRL_WIN_LSB +: 3]; // RULE3
            // protect bits only accumulate
            s_d.protect = s_q.protect | wbyte[cfg_lock_pkg::CTRL_PROT_LSB +: 4]; // RULE8
        end

        // system reset clears the lock but leaves protect bits alone
        if (sys_reset) begin
            s_d.lock = cfg_lock_pkg::LOCK_RESET; // RULE2
        end

        // straps latched on the power-good rising edge, held after
        if (power_good_rise) begin
            s_d.straps = straps_in; // RULE14
        end
    end

    // ==========================================================
    // state register; presetn stands for power-on

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.lock       <= cfg_lock_pkg::LOCK_RESET; // RULE2
            s_q.window_sel <= cfg_lock_pkg::WIN_RESET; // RULE5
            s_q.protect    <= cfg_lock_pkg::PROT_RESET; // RULE8
            s_q.straps     <= cfg_lock_pkg::STRAPS_RESET;
            s_q.power_good_prev <= 1'b0;
            s_q.rdata      <= 8'h00;
            s_q.err        <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // bus outputs

    // locked writes answer like any other write, without error
    assign pready  = 1'b1;
    assign prdata  = {24'h000000, s_q.rdata};
    assign pslverr = psel && penable && s_q.err; // RULE15

    // ==========================================================
    // cpu ownership window

    cpu_window_timer #(
        .CYC_US (CYC_US)
    ) cpu_window_timer_inst (
        .pclk              (pclk),
        .presetn           (presetn),
        .window_sel        (s_q.window_sel),
        .refresh_n         (refresh_n),
        .cpu_window_active (cpu_window_active)
    );

    // other requesters wait out the window
    assign other_grant_allowed = !cpu_window_active; // RULE4

    // ==========================================================
    // boot rom select gating

    // combinational so the chip select keeps the decode timing;
    // a protected segment never sees the select go low
    assign boot_rom_select_n = rom_select_raw_n
                             | seg_protected(rom_seg_addr, s_q.protect); // RULE6

    // ==========================================================
    // pin functions and cache status from held straps

    assign ext_power_mgmt_sel   = s_q.straps.pin_function_strap_3; // RULE11
    assign row_strobe_sel       = s_q.straps.pin_function_strap_1; // RULE12
    assign zero_wait_state_sel  = s_q.straps.pin_function_strap_0; // RULE13
    assign cache_module_present = !s_q.straps.cache_module_present_n; // RULE9
    assign cache_write_through  = s_q.straps.cache_policy_strap; // RULE10
    assign config_locked        = s_q.lock;

endmodule

// ### hdl/cpu_window_timer.sv
// cpu bus ownership window timer started at the end of each refresh
`timescale 1ns/1ps

module cpu_window_timer #(
    parameter int CYC_US = cfg_lock_pkg::CYC_PER_US
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic [2:0] window_sel,
    input  wire logic       refresh_n,
    // status
    output logic            cpu_window_active
);

    typedef struct packed {
        cfg_lock_pkg::win_state_t st;
        logic                     refresh_n_prev;
        logic [7:0]               div;
        logic [2:0]               us_left;
    } tstate_t;

    tstate_t s_q;
    tstate_t s_d;
    logic    refresh_end;
    logic    us_tick;
    logic    enabled;

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.refresh_n_prev = refresh_n;
        refresh_end = !s_q.refresh_n_prev && refresh_n;
        us_tick = (s_q.div == 8'(CYC_US - 1));
        enabled = (window_sel <= cfg_lock_pkg::WIN_MAX_ON);
        unique case (s_q.st)
            cfg_lock_pkg::WIN_IDLE: begin
                s_d.div = 8'h00;
            end
            cfg_lock_pkg::WIN_RUN: begin
                // one-cycle microsecond enable from the divider
                if (us_tick) begin
                    s_d.div = 8'h00;
                    s_d.us_left = s_q.us_left - 3'h1;
                    if (s_q.us_left == 3'h1) begin
                        s_d.st = cfg_lock_pkg::WIN_IDLE; // RULE4
                    end
                end else begin
                    s_d.div = s_q.div + 8'h01;
                end
            end
            default: begin
                s_d.st = cfg_lock_pkg::WIN_IDLE;
            end
        endcase
        // a fresh refresh end restarts the window from its full length
        if (refresh_end && enabled) begin
            s_d.st = cfg_lock_pkg::WIN_RUN; // RULE4
            s_d.div = 8'h00;
            s_d.us_left = window_sel + 3'h1; // RULE3
        end
        // reprogramming to disabled drops any window in progress
        if (!enabled) begin
            s_d.st = cfg_lock_pkg::WIN_IDLE; // RULE3
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{cfg_lock_pkg::WIN_IDLE, 1'b1, 8'h00, 3'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_window_active = (s_q.st == cfg_lock_pkg::WIN_RUN);

endmodule

// ### pkg/cfg_lock_pkg.sv
// constants and types for the configuration lock and strap status block
package cfg_lock_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_CTRL    = 8'h3b;
    localparam logic [7:0] IDX_STATUS  = 8'h3c;
    localparam logic [7:0] IDX_LOCK_LO = 8'h20;
    localparam logic [7:0] IDX_LOCK_HI = 8'h3f;

    // ==========================================================
    // control register field positions
    localparam int CTRL_LOCK_BIT   = 7;
    localparam int CTRL_WIN_LSB    = 4;
    localparam int CTRL_PROT_LSB   = 0;

    // status register field positions
    localparam int STS_CMOD_BIT    = 7;
    localparam int STS_POLICY_BIT  = 6;
    localparam int STS_FN3_BIT     = 3;
    localparam int STS_FN1_BIT     = 1;
    localparam int STS_FN0_BIT     = 0;

    // ==========================================================
    // values after reset
    localparam logic       LOCK_RESET  = 1'b0;
    localparam logic [2:0] WIN_RESET   = 3'b100;
    localparam logic [3:0] PROT_RESET  = 4'h0;

    // window codes: 000..011 give 1..4 us, 100 and above disable
    localparam logic [2:0] WIN_MAX_ON  = 3'b011;
    localparam logic [2:0] WIN_OFF     = 3'b100;

    // ==========================================================
    // timing
    localparam int CLK_KHZ         = 125000;
    localparam int WIN_UNIT_NS     = 1000;
    localparam int CYC_PER_US      = (WIN_UNIT_NS * CLK_KHZ + 999999) / 1000000;

    // ==========================================================
    // strap lines sampled at the power-good rising edge
    typedef struct packed {
        logic cache_module_present_n;
        logic cache_policy_strap;
        logic pin_function_strap_3;
        logic pin_function_strap_1;
        logic pin_function_strap_0;
    } straps_t;

    localparam straps_t STRAPS_RESET = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    // timer states
    typedef enum logic [1:0] {
        WIN_IDLE = 2'b01,
        WIN_RUN  = 2'b10
    } win_state_t;

endpackage

// ### tb/config_lock_and_strap_status_bench.sv
// self-checking bench for the config lock and strap status block
`timescale 1ns/1ps

module config_lock_and_strap_status_bench;
    // short microsecond so windows stay brief
    localparam int CYC = 4;
    logic                  pclk, presetn, psel, penable, pwrite, sys_reset;
    logic                  power_good_in, refresh_n, rom_select_raw_n;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata;
    logic [3:0]            pstrb, rom_seg_addr;
    cfg_lock_pkg::straps_t straps_in;
    logic                  pready, pslverr, cpu_window_active, other_grant_allowed;
    logic                  boot_rom_select_n, ext_power_mgmt_sel, row_strobe_sel;
    logic                  zero_wait_state_sel, cache_module_present, cache_write_through;
    logic                  config_locked;
    logic [4:0]            strap_outs;
    logic [31:0]           rd_q;
    logic                  err_q;
    int                    fail_count = 0;
    int                    n_tests = 0;

    assign strap_outs = {cache_module_present, cache_write_through, ext_power_mgmt_sel,
                         row_strobe_sel, zero_wait_state_sel};

    config_lock_and_strap_status #(.CYC_US(CYC)) config_lock_and_strap_status_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .sys_reset, .power_good_in, .straps_in, .refresh_n,
        .cpu_window_active, .other_grant_allowed, .rom_seg_addr, .rom_select_raw_n,
        .boot_rom_select_n, .ext_power_mgmt_sel, .row_strobe_sel, .zero_wait_state_sel,
        .cache_module_present, .cache_write_through, .config_locked);

    // ==========================================
    // clock and watchdog (whole run is well under 1000 cycles)
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    initial begin
        #100000;
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        wrap_up();
    end

    // ==========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] strb);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h00a5a5, d};
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the slave; only the watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic e);
        apb(1'b0, idx, 8'h00, 4'h0);
        chk(rd_q, exp, "read data");
        chk({31'h0, err_q}, {31'h0, e}, "read error");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
        apb(1'b1, idx, d, s);
        chk({31'h0, err_q}, 32'h0, "write error");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        int         cnt;
        int         gcnt;
        logic [4:0] pat;
        {presetn, psel, penable, pwrite, sys_reset, power_good_in} = '0;
        {refresh_n, rom_select_raw_n} = 2'b11;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        rom_seg_addr = '0;
        straps_in = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h3b, 32'h40, 1'b0);
        rd(8'h3c, 32'h80, 1'b0);
        $display("test reset done");
        // straps latch at power good rise; later changes are ignored
        for (int i = 0; i < 2; i++) begin
            pat = i ? 5'b01010 : 5'b10101;
            @(posedge pclk);
            straps_in     <= pat;
            power_good_in <= 1'b0;
            @(posedge pclk);
            power_good_in <= 1'b1;
            repeat (2) @(posedge pclk);
            straps_in <= ~pat;
            rd(8'h3c, {24'h0, pat[4:3], 2'b00, pat[2], 1'b0, pat[1:0]}, 1'b0);
            chk({27'h0, strap_outs}, {27'h0, ~pat[4], pat[3:0]}, "strap outputs");
        end
        $display("test straps done");
        // window codes 000 to 100, refresh ending after a one-cycle pulse
        for (int s = 0; s < 5; s++) begin
            wr(8'h3b, {1'b0, s[2:0], 4'h0}, 4'h1);
            @(posedge pclk);
            refresh_n <= 1'b0;
            @(posedge pclk);
            refresh_n <= 1'b1;
            cnt = 0;
            gcnt = 0;
            // sample mid-cycle so the window flop has settled
            repeat (30) begin
                @(negedge pclk);
                if (cpu_window_active === 1'b1) cnt++;
                if (other_grant_allowed === 1'b0) gcnt++;
            end
            chk(cnt, s < 4 ? (s + 1) * CYC : 0, "window length");
            chk(gcnt, s < 4 ? (s + 1) * CYC : 0, "grant held off");
        end
        $display("test window done");
        // protect bits accumulate and never clear; strobe off is ignored
        wr(8'h3b, 8'h48, 4'h1);
        wr(8'h3b, 8'h41, 4'h1);
        wr(8'h3b, 8'h40, 4'h1);
        wr(8'h3b, 8'h4f, 4'h0);
        rd(8'h3b, 32'h49, 1'b0);
        for (int a = 0; a < 32; a++) begin
            @(posedge pclk);
            rom_seg_addr     <= a[3:0];
            rom_select_raw_n <= a[4];
            @(posedge pclk);
            chk(boot_rom_select_n, a[4] || a[3:0] == 4'hf || a[3:0] == 4'hd, "rom sel");
        end
        $display("test protect done");
        // lock freezes the register until system reset
        wr(8'h3b, 8'hc9, 4'h1);
        @(negedge pclk);
        chk(config_locked, 1'b1, "lock set");
        wr(8'h3b, 8'h06, 4'h1);
        rd(8'h3b, 32'hc9, 1'b0);
        @(posedge pclk);
        sys_reset <= 1'b1;
        @(posedge pclk);
        sys_reset <= 1'b0;
        @(posedge pclk);
        chk(config_locked, 1'b0, "lock after reset");
        wr(8'h3b, 8'h20, 4'h1);
        rd(8'h3b, 32'h29, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        wr(8'h3c, 8'h00, 4'h1);
        rd(8'h3c, 32'h42, 1'b0);
        $display("test lock done");
        wrap_up();
    end
endmodule

// ### tb/config_lock_chk.sv
// assertion checker for the config lock and strap status block
`timescale 1ns/1ps

module config_lock_chk #(
    parameter int ADDR_W = 12,
    parameter int CYC_US = 4
) (
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_W-1:0]     paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // system side
    input wire logic                  sys_reset,
    input wire logic                  power_good_in,
    input wire cfg_lock_pkg::straps_t straps_in,
    input wire logic                  refresh_n,
    input wire logic                  cpu_window_active,
    input wire logic                  other_grant_allowed,
    input wire logic [3:0]            rom_seg_addr,
    input wire logic                  rom_select_raw_n,
    input wire logic                  boot_rom_select_n,
    input wire logic                  ext_power_mgmt_sel,
    input wire logic                  row_strobe_sel,
    input wire logic                  zero_wait_state_sel,
    input wire logic                  cache_module_present,
    input wire logic                  cache_write_through,
    input wire logic                  config_locked
);
    // ==========================================
    // cycles since the last refresh end, saturating so it never wraps
    int   since_q;
    logic ref_q;
    logic rd_acc;
    assign rd_acc = psel && penable && !pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_q <= 0;
            ref_q   <= 1'b1;
        end else begin
            ref_q   <= refresh_n;
            since_q <= (refresh_n && !ref_q) ? 0 : (since_q < 9999 ? since_q + 1 : since_q);
        end
    end

    // ==========================================
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_rom_raw_pass: assert property (rom_select_raw_n |-> boot_rom_select_n)
        else $error("rom select active without raw select");
    a_rom_open_seg: assert property (!rom_select_raw_n &&
        !(rom_seg_addr inside {4'hc, 4'hd, 4'he, 4'hf}) |-> !boot_rom_select_n)
        else $error("rom select blocked outside boot area");
    a_grant_split: assert property (other_grant_allowed == !cpu_window_active)
        else $error("grant permission not inverse of window");
    a_window_start: assert property ($rose(cpu_window_active) |->
        $past(refresh_n) && !$past(refresh_n, 2))
        else $error("window opened without refresh end");
    a_window_bound: assert property (cpu_window_active |-> since_q < 4 * CYC_US)
        else $error("window longer than four microseconds");
    a_lock_sticky: assert property (config_locked && !sys_reset |=> config_locked)
        else $error("lock cleared without reset");
    a_lock_clear: assert property (sys_reset |=> !config_locked)
        else $error("system reset left lock set");
    a_mapped_ok: assert property (psel && penable && paddr[9:2] inside {8'h3b, 8'h3c}
        |-> pready && !pslverr)
        else $error("mapped access flagged error");
    a_status_read: assert property (
        rd_acc && paddr[9:2] == 8'h3c |->
        prdata == {24'h0, !cache_module_present, cache_write_through, 2'b00,
        ext_power_mgmt_sel, 1'b0, row_strobe_sel, zero_wait_state_sel})
        else $error("status read disagrees with strap outputs");
    a_strap_latch: assert property ($rose(power_good_in) |=>
        {ext_power_mgmt_sel, row_strobe_sel, zero_wait_state_sel, cache_write_through} ==
        $past({straps_in.pin_function_strap_3, straps_in.pin_function_strap_1,
        straps_in.pin_function_strap_0, straps_in.cache_policy_strap}) &&
        cache_module_present == !$past(straps_in.cache_module_present_n))
        else $error("straps not latched at power good");
    a_lock_read: assert property (rd_acc && paddr[9:2] == 8'h3b |->
        prdata[7] == config_locked)
        else $error("lock bit readback wrong");
endmodule

bind config_lock_and_strap_status config_lock_chk #(
    .ADDR_W(ADDR_W),
    .CYC_US(CYC_US)
) config_lock_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .sys_reset, .power_good_in, .straps_in,
    .refresh_n, .cpu_window_active, .other_grant_allowed, .rom_seg_addr,
    .rom_select_raw_n, .boot_rom_select_n, .ext_power_mgmt_sel, .row_strobe_sel,
    .zero_wait_state_sel, .cache_module_present, .cache_write_through, .config_locked);
